// ### verilog/msi_pkg.sv
package msi_pkg;

  // position counter, one electrical cycle of finest entries
  localparam int         POS_W       = 7;
  localparam logic [6:0] POS_HOME    = 7'h10;
  localparam logic [6:0] FULL_OFFSET = 7'h10;
  localparam logic [5:0] QUARTER_TOP = 6'h20;
  localparam int         LEVEL_W     = 7;

  // tri-level select encoding as seen after the pad comparators
  localparam logic [1:0] TRI_LOW  = 2'h0;
  localparam logic [1:0] TRI_HIGH = 2'h1;
  localparam logic [1:0] TRI_HIZ  = 2'h2;

  // register byte offsets
  localparam logic [31:0] REG_CTRL    = 32'h0000_0000;
  localparam logic [31:0] REG_STATUS  = 32'h0000_0004;
  localparam logic [31:0] REG_CURRENT = 32'h0000_0008;

  // field positions
  localparam int CTRL_SLEEP_BIT = 0;
  localparam int CTRL_UVLO_BIT  = 1;
  localparam int STAT_POS_LSB   = 0;
  localparam int STAT_MODE_LSB  = 8;
  localparam int STAT_BOTH_BIT  = 11;
  localparam int STAT_DIR_BIT   = 12;
  localparam int STAT_OFF_BIT   = 13;
  localparam int STAT_HOLD_BIT  = 14;
  localparam int CUR_A_LSB      = 0;
  localparam int CUR_A_NEG_BIT  = 7;
  localparam int CUR_B_LSB      = 8;
  localparam int CUR_B_NEG_BIT  = 15;

  localparam logic [1:0] CTRL_RESET  = 2'h0;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    MSI_FULL,
    MSI_HALF,
    MSI_QUARTER,
    MSI_EIGHTH,
    MSI_SIXTEENTH,
    MSI_THIRTYSECOND
  } msi_mode_t;

  typedef struct packed {
    logic [1:0] resolutionSelHi;
    logic [1:0] resolutionSelLo;
  } msi_sel_t;

  typedef struct packed {
    logic               windingOutPos;
    logic               windingOutNeg;
    logic [LEVEL_W-1:0] level;
  } msi_bridge_t;

  typedef struct packed {
    logic        awvalid;
    logic [31:0] awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [31:0] araddr;
    logic        rready;
  } msi_axi_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } msi_axi_rsp_t;

endpackage

// ### verilog/msi_wave_rom.sv
`timescale 1ns/1ps

module msi_wave_rom
  import msi_pkg::*;
(
  input  wire logic               ref_clk,
  input  wire logic               arst_n,
  input  wire logic [5:0]         addrA,
  input  wire logic [5:0]         addrB,
  output logic      [LEVEL_W-1:0] dataA,
  output logic      [LEVEL_W-1:0] dataB
);

  typedef struct packed {
    logic [LEVEL_W-1:0] dataA;
    logic [LEVEL_W-1:0] dataB;
  } msi_rom_state_t;

  msi_rom_state_t rom_reg;
  msi_rom_state_t rom_next;

  // quarter wave in percent, index 0 is 0 deg, index 32 is 90 deg
  function automatic logic [LEVEL_W-1:0] quarterWave(input logic [5:0] k);
    case (k)
      6'h00: quarterWave = 7'h00;
      6'h01: quarterWave = 7'h05;
      6'h02: quarterWave = 7'h0A;
      6'h03: quarterWave = 7'h0F;
      6'h04: quarterWave = 7'h14;
      6'h05: quarterWave = 7'h18;
      6'h06: quarterWave = 7'h1D;
      6'h07: quarterWave = 7'h22;
      6'h08: quarterWave = 7'h26;
      6'h09: quarterWave = 7'h2B;
      6'h0A: quarterWave = 7'h2F;
      6'h0B: quarterWave = 7'h33;
      6'h0C: quarterWave = 7'h38;
      6'h0D: quarterWave = 7'h3C;
      6'h0E: quarterWave = 7'h3F;
      6'h0F: quarterWave = 7'h43;
      6'h10: quarterWave = 7'h47;
      6'h11: quarterWave = 7'h4A;
      6'h12: quarterWave = 7'h4D;
      6'h13: quarterWave = 7'h50;
      6'h14: quarterWave = 7'h53;
      6'h15: quarterWave = 7'h56;
      6'h16: quarterWave = 7'h58;
      6'h17: quarterWave = 7'h5A;
      6'h18: quarterWave = 7'h5C;
      6'h19: quarterWave = 7'h5E;
      6'h1A: quarterWave = 7'h60;
      6'h1B: quarterWave = 7'h61;
      6'h1C: quarterWave = 7'h62;
      6'h1D: quarterWave = 7'h63;
      default: quarterWave = 7'h64;
    endcase
  endfunction

  always_comb
  begin
    rom_next.dataA = quarterWave(addrA);
    rom_next.dataB = quarterWave(addrB);
  end

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      rom_reg <= '0;
    else
      rom_reg <= rom_next;
  end

  assign dataA = rom_reg.dataA;
  assign dataB = rom_reg.dataB;

endmodule // msi_wave_rom

// ### verilog/msi_microstep_indexer.sv
`timescale 1ns/1ps

// What this block does
// [RULE1] Each qualifying step edge moves the position one resolution step in the chosen sense, and the bridges follow from the position alone.
// [RULE2] The output disable turns off only the bridge drive while the indexer keeps following step and direction.
// [RULE3] With the high select low, the low select picks full, half or quarter step, all on rising edges only.
// [RULE4] With the high select open, the low select picks eighth rising, eighth both edges or sixteenth rising.
// [RULE5] With the high select high, the low select picks sixteenth both edges, thirty-second rising or thirty-second both edges.
// [RULE6] Each select is read as low, high or open, and the controller must leave it in one of those.
// [RULE7] A resolution change mid-motion lands on the next position valid for the new resolution at the next step.
// [RULE8] Reset, undervoltage recovery and sleep exit put the indexer at home, 45 degrees, entry 16 of the finest table.
// [RULE9] Direction high walks the table upward in angle, direction low walks it in reverse.
// [RULE10] Coarser resolutions visit evenly spaced finest entries, full step only the 45 degree row and its quadrant twins.
// [RULE11] Winding levels follow the tabulated percentages per electrical angle.
// [RULE12] Positive current drives the first winding output high against the second, negative reverses it.
// [RULE13] The indexer drives both bridges itself, the controller only gives step, direction and the resolution selects.
// [RULE14] The position wraps modulo 128 finest entries in both senses.
module msi_microstep_indexer
  import msi_pkg::*;
(
  input  wire logic         ref_clk,
  input  wire logic         arst_n,
  input  wire logic         stepIn,
  input  wire logic         dirIn,
  input  wire logic         outputOffN,
  input  wire msi_sel_t     resolutionSel,
  output msi_bridge_t       windA,
  output msi_bridge_t       windB,
  input  wire msi_axi_req_t axiReq,
  output msi_axi_rsp_t      axiRsp
);

  typedef struct packed {
    logic              stepPrev;
    logic              stepSeen;
    logic [POS_W-1:0]  pos;
    logic              negAD;
    logic              negBD;
    msi_bridge_t       windA;
    msi_bridge_t       windB;
    logic              awreadyR;
    logic              wreadyR;
    logic              awHave;
    logic              wHave;
    logic [31:0]       awAddr;
    logic [31:0]       wData;
    logic [3:0]        wStrb;
    logic              bvalidR;
    logic [1:0]        bresp;
    logic              arreadyR;
    logic              rvalidR;
    logic [31:0]       rdata;
    logic [1:0]        rresp;
    logic [1:0]        ctrl;
  } msi_core_state_t;

  msi_core_state_t    core_reg;
  msi_core_state_t    core_next;
  msi_mode_t          curMode;
  logic               bothEdges;
  logic               hold;
  logic               stepRise;
  logic               stepFall;
  logic               stepMove;
  logic [POS_W-1:0]   targetPos;
  logic [5:0]         romAddrA;
  logic [5:0]         romAddrB;
  logic [LEVEL_W-1:0] romDataA;
  logic [LEVEL_W-1:0] romDataB;

  // open and any undefined code both read as the middle level
  function automatic logic [1:0] triLevel(input logic [1:0] code);
    if (code == TRI_LOW || code == TRI_HIGH)
      triLevel = code;
    else
      triLevel = TRI_HIZ;
  endfunction

  always_comb
  begin
    curMode   = MSI_FULL;
    bothEdges = 1'b0;
    case ({triLevel(resolutionSel.resolutionSelHi), triLevel(resolutionSel.resolutionSelLo)}) // RULE6
      {TRI_LOW, TRI_LOW}:   curMode = MSI_FULL;                 // RULE3
      {TRI_LOW, TRI_HIZ}:   curMode = MSI_HALF;                 // RULE3
      {TRI_LOW, TRI_HIGH}:  curMode = MSI_QUARTER;              // RULE3
      {TRI_HIZ, TRI_LOW}:   curMode = MSI_EIGHTH;               // RULE4
      {TRI_HIZ, TRI_HIZ}:
      begin
        curMode   = MSI_EIGHTH;                                  // RULE4
        bothEdges = 1'b1;
      end
      {TRI_HIZ, TRI_HIGH}:  curMode = MSI_SIXTEENTH;            // RULE4
      {TRI_HIGH, TRI_LOW}:
      begin
        curMode   = MSI_SIXTEENTH;                               // RULE5
        bothEdges = 1'b1;
      end
      {TRI_HIGH, TRI_HIZ}:  curMode = MSI_THIRTYSECOND;         // RULE5
      {TRI_HIGH, TRI_HIGH}:
      begin
        curMode   = MSI_THIRTYSECOND;                            // RULE5
        bothEdges = 1'b1;
      end
      default:              curMode = MSI_FULL;
    endcase
  end

  assign hold     = core_reg.ctrl[CTRL_SLEEP_BIT] | core_reg.ctrl[CTRL_UVLO_BIT];
  // first edge after reset only learns the pin, so a step held high through reset is no step
  assign stepRise = stepIn & ~core_reg.stepPrev & core_reg.stepSeen;
  assign stepFall = ~stepIn & core_reg.stepPrev & core_reg.stepSeen;
  assign stepMove = ~hold & (stepRise | (stepFall & bothEdges)); // RULE1

  // snapping to the grid first lets a resolution change land on a valid entry
  always_comb
  begin
    logic [POS_W-1:0] stride;
    logic [POS_W-1:0] offset;
    logic [POS_W-1:0] rel;
    logic [POS_W-1:0] down;
    stride = 7'h01;
    offset = 7'h00;
    rel    = 7'h00;
    down   = 7'h00;
    case (curMode)
      MSI_FULL:
      begin
        stride = 7'h20;
        offset = FULL_OFFSET;                                    // RULE10
      end
      MSI_HALF:         stride = 7'h10;                          // RULE10
      MSI_QUARTER:      stride = 7'h08;
      MSI_EIGHTH:       stride = 7'h04;
      MSI_SIXTEENTH:    stride = 7'h02;
      MSI_THIRTYSECOND: stride = 7'h01;
      default:          stride = 7'h01;
    endcase
    rel  = core_reg.pos - offset;
    down = rel & ~(stride - 7'h01);                              // RULE7
    if (dirIn)
      targetPos = down + stride + offset;                        // RULE9 RULE14
    else if (rel == down)
      targetPos = down - stride + offset;                        // RULE9 RULE14
    else
      targetPos = down + offset;                                 // RULE7
  end

  // quadrant fold of the quarter wave; odd quadrants swap the two look-ups
  always_comb
  begin
    if (core_reg.pos[5])
    begin
      romAddrA = {1'b0, core_reg.pos[4:0]};
      romAddrB = QUARTER_TOP - {1'b0, core_reg.pos[4:0]};
    end
    else
    begin
      romAddrA = QUARTER_TOP - {1'b0, core_reg.pos[4:0]};
      romAddrB = {1'b0, core_reg.pos[4:0]};
    end
  end

  msi_wave_rom u_wave_rom (
    .ref_clk (ref_clk),
    .arst_n  (arst_n),
    .addrA   (romAddrA),
    .addrB   (romAddrB),
    .dataA   (romDataA),
    .dataB   (romDataB)
  ); // RULE11

  always_comb
  begin
    logic offAll;
    logic [31:0] wAddr;
    logic [31:0] rAddr;
    offAll    = 1'b0;
    wAddr     = 32'h0000_0000;
    rAddr     = 32'h0000_0000;
    core_next = core_reg;

    core_next.stepPrev = stepIn;
    core_next.stepSeen = 1'b1;
    if (hold)
      core_next.pos = POS_HOME;                                  // RULE8
    else if (stepMove)
      core_next.pos = targetPos;                                 // RULE1

    core_next.negAD = core_reg.pos[6] ^ core_reg.pos[5];
    core_next.negBD = core_reg.pos[6];

    // only the drive is gated; under outputOffN the position above keeps moving, under hold it stays at POS_HOME
    offAll = outputOffN | hold;                                  // RULE2
    core_next.windA.level = offAll ? 7'h00 : romDataA;
    core_next.windB.level = offAll ? 7'h00 : romDataB;
    core_next.windA.windingOutPos = ~offAll & (romDataA != 7'h00) & ~core_reg.negAD; // RULE12
    core_next.windA.windingOutNeg = ~offAll & (romDataA != 7'h00) & core_reg.negAD;  // RULE12
    core_next.windB.windingOutPos = ~offAll & (romDataB != 7'h00) & ~core_reg.negBD; // RULE13
    core_next.windB.windingOutNeg = ~offAll & (romDataB != 7'h00) & core_reg.negBD;  // RULE13

    if (axiReq.awvalid && core_reg.awreadyR)
    begin
      core_next.awHave = 1'b1;
      core_next.awAddr = axiReq.awaddr;
    end
    if (axiReq.wvalid && core_reg.wreadyR)
    begin
      core_next.wHave = 1'b1;
      core_next.wData = axiReq.wdata;
      core_next.wStrb = axiReq.wstrb;
    end
    if (core_reg.bvalidR && axiReq.bready)
      core_next.bvalidR = 1'b0;
    if (core_next.awHave && core_next.wHave && !core_next.bvalidR)
    begin
      wAddr = {core_next.awAddr[31:2], 2'b00};
      core_next.awHave  = 1'b0;
      core_next.wHave   = 1'b0;
      core_next.bvalidR = 1'b1;
      core_next.bresp   = RESP_OKAY;
      if (wAddr == REG_CTRL)
      begin
        if (core_next.wStrb[0])
          core_next.ctrl = core_next.wData[1:0];
      end
      else if (wAddr != REG_STATUS && wAddr != REG_CURRENT)
        core_next.bresp = RESP_SLVERR;
    end
    core_next.awreadyR = ~core_next.awHave & ~core_next.bvalidR;
    core_next.wreadyR  = ~core_next.wHave & ~core_next.bvalidR;

    if (core_reg.rvalidR && axiReq.rready)
      core_next.rvalidR = 1'b0;
    if (axiReq.arvalid && core_reg.arreadyR)
    begin
      rAddr = {axiReq.araddr[31:2], 2'b00};
      core_next.rvalidR = 1'b1;
      core_next.rresp   = RESP_OKAY;
      core_next.rdata   = 32'h0000_0000;
      case (rAddr)
        REG_CTRL:
          core_next.rdata[1:0] = core_reg.ctrl;
        REG_STATUS:
        begin
          core_next.rdata[STAT_POS_LSB +: POS_W] = core_reg.pos;
          core_next.rdata[STAT_MODE_LSB +: 3]    = curMode;
          core_next.rdata[STAT_BOTH_BIT]         = bothEdges;
          core_next.rdata[STAT_DIR_BIT]          = dirIn;
          core_next.rdata[STAT_OFF_BIT]          = outputOffN;
          core_next.rdata[STAT_HOLD_BIT]         = hold;
        end
        REG_CURRENT:
        begin
          core_next.rdata[CUR_A_LSB +: LEVEL_W] = core_reg.windA.level;
          core_next.rdata[CUR_A_NEG_BIT]        = core_reg.windA.windingOutNeg;
          core_next.rdata[CUR_B_LSB +: LEVEL_W] = core_reg.windB.level;
          core_next.rdata[CUR_B_NEG_BIT]        = core_reg.windB.windingOutNeg;
        end
        default:
          core_next.rresp = RESP_SLVERR;
      endcase
    end
    core_next.arreadyR = ~core_next.rvalidR;
  end

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      core_reg      <= '0;
      core_reg.pos  <= POS_HOME;                                 // RULE8
      core_reg.ctrl <= CTRL_RESET;
    end
    else
      core_reg <= core_next;
  end

  assign windA  = core_reg.windA;
  assign windB  = core_reg.windB;
  assign axiRsp = '{awready: core_reg.awreadyR,
                    wready:  core_reg.wreadyR,
                    bvalid:  core_reg.bvalidR,
                    bresp:   core_reg.bresp,
                    arready: core_reg.arreadyR,
                    rvalid:  core_reg.rvalidR,
                    rdata:   core_reg.rdata,
                    rresp:   core_reg.rresp};

  property p_fine_fwd;
    @(posedge ref_clk) disable iff (!arst_n)
      (stepMove && dirIn && curMode == MSI_THIRTYSECOND) |=> core_reg.pos == $past(core_reg.pos) + 7'h01;
  endproperty
  a_fine_fwd: assert property (p_fine_fwd) else $error("forward step did not add one"); // RULE9

  property p_fine_rev;
    @(posedge ref_clk) disable iff (!arst_n)
      (stepMove && !dirIn && curMode == MSI_THIRTYSECOND) |=> core_reg.pos == $past(core_reg.pos) - 7'h01;
  endproperty
  a_fine_rev: assert property (p_fine_rev) else $error("reverse step did not subtract one"); // RULE1

  property p_wrap;
    @(posedge ref_clk) disable iff (!arst_n)
      (stepMove && dirIn && curMode == MSI_THIRTYSECOND && core_reg.pos == 7'h7F) |=> core_reg.pos == 7'h00;
  endproperty
  a_wrap: assert property (p_wrap) else $error("position did not wrap to zero"); // RULE14

  property p_full_grid;
    @(posedge ref_clk) disable iff (!arst_n)
      (stepMove && curMode == MSI_FULL) |=> core_reg.pos[4:0] == 5'h10;
  endproperty
  a_full_grid: assert property (p_full_grid) else $error("full step left the 45 degree rows"); // RULE10

  property p_res_change;
    @(posedge ref_clk) disable iff (!arst_n)
      (stepMove && curMode == MSI_EIGHTH) |=> core_reg.pos[1:0] == 2'h0 && core_reg.pos != $past(core_reg.pos);
  endproperty
  a_res_change: assert property (p_res_change) else $error("eighth step landed off grid"); // RULE7

  property p_both_edge;
    @(posedge ref_clk) disable iff (!arst_n)
      (stepFall && bothEdges && !hold) |=> core_reg.pos != $past(core_reg.pos);
  endproperty
  a_both_edge: assert property (p_both_edge) else $error("falling edge ignored in dual edge mode"); // RULE4

  property p_rise_only;
    @(posedge ref_clk) disable iff (!arst_n)
      (stepFall && !bothEdges && !hold) |=> $stable(core_reg.pos);
  endproperty
  a_rise_only: assert property (p_rise_only) else $error("falling edge moved a rising only mode"); // RULE3

  property p_home;
    @(posedge ref_clk) disable iff (!arst_n)
      hold |=> core_reg.pos == POS_HOME;
  endproperty
  a_home: assert property (p_home) else $error("indexer not at home during hold"); // RULE8

  property p_off;
    @(posedge ref_clk) disable iff (!arst_n)
      outputOffN |=> !windA.windingOutPos && !windA.windingOutNeg && !windB.windingOutPos
                     && !windB.windingOutNeg && windA.level == 7'h00;
  endproperty
  a_off: assert property (p_off) else $error("bridge driven while output disabled"); // RULE2

  property p_polarity;
    @(posedge ref_clk) disable iff (!arst_n)
      (core_reg.pos == 7'h30 && !outputOffN && !hold)[*3] |-> windA.windingOutNeg && windB.windingOutPos;
  endproperty
  a_polarity: assert property (p_polarity) else $error("bridge polarity wrong at 135 degrees"); // RULE12

  property p_level;
    @(posedge ref_clk) disable iff (!arst_n)
      (core_reg.pos == 7'h08 && !outputOffN && !hold)[*3] |-> windA.level == 7'h5C && windB.level == 7'h26;
  endproperty
  a_level: assert property (p_level) else $error("winding levels differ from table"); // RULE11

endmodule // msi_microstep_indexer

// ### sim/msi_step_ctrl.sv
`timescale 1ns/1ps

module msi_step_ctrl
  import msi_pkg::*;
#(
  parameter int HOLD = 19
)
(
  input  wire logic ref_clk,
  output logic      stepOut,
  output logic      dirOut,
  output msi_sel_t  selOut
);
  initial
  begin
    stepOut = 1'b0;
    dirOut  = 1'b1;
    selOut  = {TRI_LOW, TRI_LOW};
  end

  task automatic set_sel(input logic [1:0] hi, input logic [1:0] lo);
    @(posedge ref_clk);
    selOut <= {hi, lo};
    repeat (2) @(posedge ref_clk);
  endtask

  // direction settles ahead of the edge; each step level stands a full pulse width
  task automatic toggle(input logic d);
    @(posedge ref_clk);
    dirOut <= d;
    repeat (2) @(posedge ref_clk);
    stepOut <= ~stepOut;
    repeat (HOLD) @(posedge ref_clk);
  endtask
endmodule // msi_step_ctrl

// ### sim/msi_microstep_indexer_tb_top.sv
`timescale 1ns/1ps

module msi_microstep_indexer_tb_top
  import msi_pkg::*;
;
  localparam int LIMIT = 20000;
  localparam int HOME  = 16;

  typedef struct packed {
    logic [1:0] hi;
    logic [1:0] lo;
    msi_mode_t  mode;
    logic       both;
    logic [5:0] stride;
  } msi_row_t;

  logic         ref_clk;
  logic         arst_n;
  logic         stepIn;
  logic         dirIn;
  logic         outputOffN;
  logic         held;
  msi_sel_t     resolutionSel;
  msi_bridge_t  windA;
  msi_bridge_t  windB;
  msi_axi_req_t axiReq;
  msi_axi_rsp_t axiRsp;
  msi_row_t     cur;
  int           errTotal = 0;
  int           checked  = 0;
  int           cycles   = 0;
  int           pos;
  logic [31:0]  rd;
  logic [1:0]   rsp;
  logic [6:0]   lvl [33] = '{7'h64, 7'h64, 7'h64, 7'h63, 7'h62, 7'h61, 7'h60, 7'h5E, 7'h5C,
    7'h5A, 7'h58, 7'h56, 7'h53, 7'h50, 7'h4D, 7'h4A, 7'h47, 7'h43, 7'h3F, 7'h3C, 7'h38,
    7'h33, 7'h2F, 7'h2B, 7'h26, 7'h22, 7'h1D, 7'h18, 7'h14, 7'h0F, 7'h0A, 7'h05, 7'h00};
  // fine to coarse, so every coarser resolution is first entered off its own grid
  msi_row_t     rows [9] = '{
    '{TRI_HIGH, TRI_HIGH, MSI_THIRTYSECOND, 1'h1, 6'h01},
    '{TRI_HIGH, TRI_HIZ, MSI_THIRTYSECOND, 1'h0, 6'h01},
    '{TRI_HIGH, TRI_LOW, MSI_SIXTEENTH, 1'h1, 6'h02},
    '{TRI_HIZ, TRI_HIGH, MSI_SIXTEENTH, 1'h0, 6'h02},
    '{TRI_HIZ, TRI_HIZ, MSI_EIGHTH, 1'h1, 6'h04},
    '{TRI_HIZ, TRI_LOW, MSI_EIGHTH, 1'h0, 6'h04},
    '{TRI_LOW, TRI_HIGH, MSI_QUARTER, 1'h0, 6'h08},
    '{TRI_LOW, TRI_HIZ, MSI_HALF, 1'h0, 6'h10},
    '{TRI_LOW, TRI_LOW, MSI_FULL, 1'h0, 6'h20}};

  msi_microstep_indexer msi_microstep_indexer_i (
    .ref_clk       (ref_clk),
    .arst_n        (arst_n),
    .stepIn        (stepIn),
    .dirIn         (dirIn),
    .outputOffN    (outputOffN),
    .resolutionSel (resolutionSel),
    .windA         (windA),
    .windB         (windB),
    .axiReq        (axiReq),
    .axiRsp        (axiRsp)
  );

  msi_step_ctrl #(.HOLD(19)) msi_step_ctrl_i (
    .ref_clk (ref_clk),
    .stepOut (stepIn),
    .dirOut  (dirIn),
    .selOut  (resolutionSel)
  );

  function automatic int step_to(input int p, input int s, input logic d);
    int r;
    r = (p - ((s == 32) ? 16 : 0) + 128) % s;
    if (d)
      return (p - r + s) % 128;
    return (r == 0) ? (p - s + 128) % 128 : (p - r + 128) % 128;
  endfunction

  function automatic msi_bridge_t wind_of(input int p, input logic dark);
    int   q;
    logic neg;
    q   = p % 64;
    neg = (p > 32) && (p < 96);
    if (q > 32)
      q = 64 - q;
    if (dark || lvl[q] == 7'h00)
      return '0;
    return {~neg, neg, lvl[q]};
  endfunction

  function automatic logic [31:0] cur_word(input int p);
    msi_bridge_t a;
    msi_bridge_t b;
    a = wind_of(p, 1'b0);
    b = wind_of((p + 96) % 128, 1'b0);
    return {16'h0, b.windingOutNeg, b.level, a.windingOutNeg, a.level};
  endfunction

  task automatic summarize();
    if (errTotal == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (e !== g)
    begin
      errTotal++;
      $display("unexpected %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic axi_wr(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge ref_clk);
    axiReq.awvalid <= 1'b1;
    axiReq.awaddr  <= a;
    axiReq.wvalid  <= 1'b1;
    axiReq.wdata   <= d;
    axiReq.wstrb   <= 4'hF;
    axiReq.bready  <= 1'b1;
    do
    begin
      @(posedge ref_clk);
      if (axiRsp.awready)
        axiReq.awvalid <= 1'b0;
      if (axiRsp.wready)
        axiReq.wvalid <= 1'b0;
    end
    while (axiRsp.bvalid !== 1'b1);
    r = axiRsp.bresp;
    axiReq.bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge ref_clk);
    axiReq.arvalid <= 1'b1;
    axiReq.araddr  <= a;
    axiReq.rready  <= 1'b1;
    do
    begin
      @(posedge ref_clk);
      if (axiRsp.arready)
        axiReq.arvalid <= 1'b0;
    end
    while (axiRsp.rvalid !== 1'b1);
    d = axiRsp.rdata;
    r = axiRsp.rresp;
    axiReq.rready <= 1'b0;
  endtask

  task automatic chk_status();
    axi_rd(REG_STATUS, rd, rsp);
    chk("status", {17'h0, held, outputOffN, dirIn, cur.both, cur.mode, 1'h0, 7'(pos)}, rd);
  endtask

  task automatic check_wind();
    chk("windA", 32'(wind_of(pos, outputOffN || held)), 32'(windA));
    chk("windB", 32'(wind_of((pos + 96) % 128, outputOffN || held)), 32'(windB));
  endtask

  task automatic step(input logic d);
    msi_step_ctrl_i.toggle(d);
    if ((stepIn || cur.both) && !held)
      pos = step_to(pos, int'(cur.stride), d);
    check_wind();
  endtask

  task automatic settle();
    repeat (3) @(posedge ref_clk);
  endtask

  initial
  begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == LIMIT)
    begin
      errTotal++;
      summarize();
    end
  end

  initial
  begin
    arst_n     = 1'b0;
    outputOffN = 1'b0;
    held       = 1'b0;
    axiReq     = '0;
    pos        = HOME;
    cur        = rows[8];
    repeat (12) @(posedge ref_clk);
    arst_n <= 1'b1;
    settle();
    check_wind();
    chk_status();
    foreach (rows[i])
    begin
      msi_step_ctrl_i.set_sel(rows[i].hi, rows[i].lo);
      cur = rows[i];
      chk_status();
      for (int k = 0; k < 10; k++)
        step(k < 5);
      chk_status();
      axi_rd(REG_CURRENT, rd, rsp);
      chk("current", cur_word(pos), rd);
    end
    @(posedge ref_clk);
    outputOffN <= 1'b1;
    settle();
    check_wind();
    step(1'b1);
    step(1'b1);
    chk_status();
    @(posedge ref_clk);
    outputOffN <= 1'b0;
    settle();
    check_wind();
    for (int b = 0; b < 2; b++)
    begin
      axi_wr(REG_CTRL, 32'h0000_0001 << b, rsp);
      chk("bresp", 32'(RESP_OKAY), 32'(rsp));
      held = 1'b1;
      pos  = HOME;
      settle();
      check_wind();
      chk_status();
      step(1'b1);
      step(1'b1);
      axi_wr(REG_CTRL, 32'h0000_0000, rsp);
      held = 1'b0;
      pos  = HOME;
      settle();
      check_wind();
      chk_status();
    end
    step(1'b0);
    step(1'b1);
    step(1'b1);
    axi_rd(32'h0000_000C, rd, rsp);
    chk("rresp", 32'(RESP_SLVERR), 32'(rsp));
    chk("rdata", 32'h0000_0000, rd);
    axi_wr(REG_STATUS, 32'hFFFF_FFFF, rsp);
    chk("bresp", 32'(RESP_OKAY), 32'(rsp));
    chk_status();
    @(posedge ref_clk);
    arst_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    arst_n <= 1'b1;
    pos = HOME;
    settle();
    check_wind();
    chk_status();
    msi_step_ctrl_i.set_sel(TRI_HIGH, 2'h3);
    cur = rows[1];
    chk_status();
    for (int k = 0; k < 36; k++)
      step(k > 33);
    chk_status();
    summarize();
  end
endmodule // msi_microstep_indexer_tb_top
